// [core/port_mac_cfg.svh]
`ifndef PORT_MAC_CFG_SVH
`define PORT_MAC_CFG_SVH

// Register byte offsets
`define OFS_CLOCK_RESET   8'h00
`define OFS_MISC_CONTROL  8'h04
`define OFS_EVENT_FLAGS   8'h2c

// Reset and speed control field positions
`define BIT_MAC_TRANSMIT_RESET    7
`define BIT_MAC_RECEIVE_RESET    6
`define BIT_CODING_TRANSMIT_RESET    5
`define BIT_CODING_RECEIVE_RESET    4
`define BIT_PORT_RST      3
`define BIT_LINE_INTERFACE_RESET       2
`define SPEED_HI          1
`define SPEED_LO          0
`define CLOCK_RESET_INIT  8'hfc

// Misc control field positions
`define BIT_PASS_PAUSE    2
`define BIT_PASS_CONTROL  1
`define BIT_LOOPBACK      0
`define MISC_INIT         3'h0

// Event flag positions
`define BIT_RX_GAP        9
`define BIT_RX_PREAMBLE   8
`define BIT_RX_EXT        7
`define BIT_RX_EXT_ERR    6
`define BIT_RX_GARBAGE    5
`define BIT_TX_RETRANS    4
`define BIT_TX_JAM        3
`define BIT_TX_OVERFLOW   2
`define BIT_TX_OVERSIZE   1
`define BIT_TX_ABORT      0
`define FLAGS_INIT        10'h000

// Frame recognition constants
`define MIN_GAP_BYTES     8'h0c
`define MIN_PREAMBLE      8'h08
`define CTRL_ETHERTYPE    16'h8808
`define PAUSE_OPCODE      16'h0001

`endif

// [core/port_mac_pkg.sv]
package port_mac_pkg;
  // Link speed selector
  typedef enum logic [1:0] {
    speed_none = 2'h0,
    speed_giga = 2'h1,
    speed_100m = 2'h2,
    speed_10m  = 2'h3
  } link_speed_t;
endpackage

// [core/port_mac_status_and_mode.sv]
// Chosen here: the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "port_mac_cfg.svh"
// Operation
// - Short receive gap sets bit 9
// - Short preamble sets bit 8
// - Carrier extend sets bit 7
// - Carrier extend error sets bit 6
// - Unframed receive bytes set bit 5
// - Retransmit request sets bit 4
// - Host jam sets bit 3
// - Transmit queue overrun sets bit 2
// - Frame over 64K sets bit 1
// - Host abort done sets bit 0
// - Flags clear by writing one
// - Line reset honoured on ports 10, 11
// - Two-bit speed field, resets to none
// - Pause frames forwarded when enabled
// - Pause obeyed regardless of forwarding
// - Other control frames forwarded when enabled
// - Loopback bit loops core bus
module port_mac_status_and_mode #(
  parameter int PORT_NUMBER = 0
) (
  // Clock and reset
  input  wire logic                      clk_i,
  input  wire logic                      rst_i,
  // Wishbone slave
  input  wire logic                      cyc_i,
  input  wire logic                      stb_i,
  input  wire logic                      we_i,
  input  wire logic [7:0]                adr_i,
  input  wire logic [3:0]                sel_i,
  input  wire logic [31:0]               dat_i,
  output logic      [31:0]               dat_o,
  output logic                           ack_o,
  output logic                           err_o,
  // Receive event pulses
  input  wire logic                      rx_gap_short_i,
  input  wire logic                      rx_preamble_short_i,
  input  wire logic                      rx_extension_i,
  input  wire logic                      rx_extension_error_i,
  input  wire logic                      rx_garbage_i,
  // Transmit event pulses
  input  wire logic                      tx_retransmit_i,
  input  wire logic                      tx_jamming_i,
  input  wire logic                      tx_queue_overflow_i,
  input  wire logic                      tx_oversize_i,
  input  wire logic                      tx_abort_done_i,
  // Received control frame classification
  input  wire logic                      rx_frame_start_i,
  input  wire logic [15:0]               rx_ethertype_i,
  input  wire logic [15:0]               rx_opcode_i,
  input  wire logic                      obey_pause_cfg_i,
  // Sub-block controls
  output logic                           mac_transmit_reset_o,
  output logic                           mac_receive_reset_o,
  output logic                           coding_transmit_reset_o,
  output logic                           coding_receive_reset_o,
  output logic                           port_reset_o,
  output logic                           line_interface_reset_o,
  output port_mac_pkg::link_speed_t      link_speed_o,
  output logic                           core_bus_loopback_o,
  // Frame disposition
  output logic                           rx_forward_o,
  output logic                           rx_drop_o,
  output logic                           pause_obey_o
);
  import port_mac_pkg::*;

  localparam logic LINE_RESET_PRESENT = (PORT_NUMBER == 10) || (PORT_NUMBER == 11);

  logic [7:0]  clock_reset;
  logic [2:0]  misc_control;
  logic [9:0]  event_flags;
  logic [9:0]  event_in;
  logic [9:0]  clear_mask;
  logic        wr_strobe;
  logic        rd_strobe;
  logic        hit_clock;
  logic        hit_misc;
  logic        hit_flags;
  logic        hit_any;
  logic [31:0] next_dat;
  logic        is_control;
  logic        is_pause;

  ////////////////////////////////////////////////////////////////////////
  // Bus decode
  assign hit_clock = (adr_i == `OFS_CLOCK_RESET);
  assign hit_misc  = (adr_i == `OFS_MISC_CONTROL);
  assign hit_flags = (adr_i == `OFS_EVENT_FLAGS);
  assign hit_any   = hit_clock | hit_misc | hit_flags;
  assign wr_strobe = cyc_i & stb_i & we_i & ~ack_o & ~err_o & hit_any;
  assign rd_strobe = cyc_i & stb_i & ~we_i & ~ack_o & ~err_o;

  // One-cycle answer, dropped the cycle after
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      err_o <= 1'b0;
    end else begin
      ack_o <= cyc_i & stb_i & hit_any & ~ack_o & ~err_o;
      err_o <= cyc_i & stb_i & ~hit_any & ~ack_o & ~err_o;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Reset and speed register
  // asserted after reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      clock_reset <= `CLOCK_RESET_INIT;
    end else if (wr_strobe && hit_clock && sel_i[0]) begin
      clock_reset <= dat_i[7:0];
    end
  end

  // Misc control register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      misc_control <= `MISC_INIT;
    end else if (wr_strobe && hit_misc && sel_i[0]) begin
      misc_control <= dat_i[2:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Event collection
  always_comb begin
    event_in = '0;
    event_in[`BIT_RX_GAP]      = rx_gap_short_i;
    event_in[`BIT_RX_PREAMBLE] = rx_preamble_short_i;
    event_in[`BIT_RX_EXT]      = rx_extension_i;
    event_in[`BIT_RX_EXT_ERR]  = rx_extension_error_i;
    event_in[`BIT_RX_GARBAGE]  = rx_garbage_i;
    event_in[`BIT_TX_RETRANS]  = tx_retransmit_i;
    event_in[`BIT_TX_JAM]      = tx_jamming_i;
    event_in[`BIT_TX_OVERFLOW] = tx_queue_overflow_i;
    event_in[`BIT_TX_OVERSIZE] = tx_oversize_i;
    event_in[`BIT_TX_ABORT]    = tx_abort_done_i;
  end

  // Write-one clear mask from byte lanes 0 and 1
  assign clear_mask = (wr_strobe && hit_flags) ?
                      {dat_i[9:8] & {2{sel_i[1]}}, dat_i[7:0] & {8{sel_i[0]}}} : 10'h000;

  // Sticky flags
  // write one clears
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      event_flags <= `FLAGS_INIT;
    end else begin
      event_flags <= (event_flags & ~clear_mask) | event_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read data
  always_comb begin
    next_dat = 32'h0000_0000;
    if (hit_clock) begin
      next_dat[7:0] = clock_reset;
    end else if (hit_misc) begin
      next_dat[2:0] = misc_control;
    end else if (hit_flags) begin
      next_dat[9:0] = event_flags;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= 32'h0000_0000;
    end else if (rd_strobe) begin
      dat_o <= next_dat;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Sub-block reset and mode outputs
  // hold while one
  assign mac_transmit_reset_o    = clock_reset[`BIT_MAC_TRANSMIT_RESET];
  assign mac_receive_reset_o     = clock_reset[`BIT_MAC_RECEIVE_RESET];
  assign coding_transmit_reset_o = clock_reset[`BIT_CODING_TRANSMIT_RESET];
  assign coding_receive_reset_o  = clock_reset[`BIT_CODING_RECEIVE_RESET];
  assign port_reset_o            = clock_reset[`BIT_PORT_RST];
  assign line_interface_reset_o  = LINE_RESET_PRESENT & clock_reset[`BIT_LINE_INTERFACE_RESET];
  assign link_speed_o = link_speed_t'(clock_reset[`SPEED_HI:`SPEED_LO]);
  assign core_bus_loopback_o = misc_control[`BIT_LOOPBACK];

  ////////////////////////////////////////////////////////////////////////
  // Control frame classification
  assign is_control = (rx_ethertype_i == `CTRL_ETHERTYPE);
  assign is_pause   = is_control && (rx_opcode_i == `PAUSE_OPCODE);

  // Forward or drop decision at frame start
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_forward_o <= 1'b0;
      rx_drop_o    <= 1'b0;
    end else if (rx_frame_start_i) begin
      if (is_pause) begin
        rx_forward_o <= misc_control[`BIT_PASS_PAUSE];
        rx_drop_o    <= ~misc_control[`BIT_PASS_PAUSE];
      end else if (is_control) begin
        rx_forward_o <= misc_control[`BIT_PASS_CONTROL];
        rx_drop_o    <= ~misc_control[`BIT_PASS_CONTROL];
      end else begin
        rx_forward_o <= 1'b1;
        rx_drop_o    <= 1'b0;
      end
    end else begin
      rx_forward_o <= 1'b0;
      rx_drop_o    <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pause_obey_o <= 1'b0;
    end else begin
      pause_obey_o <= rx_frame_start_i & is_pause & obey_pause_cfg_i;
    end
  end

endmodule
`default_nettype wire

// [tb/port_mac_chk.sv]
`timescale 1ns/1ps
`default_nettype none
module port_mac_chk #(parameter int PORT_NUMBER = 0) (
  // Bus side
  input wire logic        clk_i, rst_i, cyc_i, stb_i, ack_o, err_o,
  input wire logic [7:0]  adr_i,
  // Frame and control side
  input wire logic        rx_frame_start_i, obey_pause_cfg_i, rx_forward_o, pause_obey_o,
  input wire logic [15:0] rx_ethertype_i, rx_opcode_i,
  input wire logic        mac_transmit_reset_o, line_interface_reset_o, core_bus_loopback_o,
  input wire port_mac_pkg::link_speed_t link_speed_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic req, mapped, ctl;
  // Decode of a fresh request and frame kind
  assign req    = cyc_i && stb_i && !ack_o && !err_o;
  assign mapped = adr_i == 8'h00 || adr_i == 8'h04 || adr_i == 8'h2c;
  assign ctl    = rx_ethertype_i == 16'h8808;
  //////////////////////////////////////////////////////////////////
  ack_single_a: assert property (ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
  mapped_ack_a: assert property (req && mapped |=> ack_o && !err_o)
    else $error("mapped access not acked");
  unmapped_err_a: assert property (req && !mapped |=> err_o && !ack_o)
    else $error("unmapped access not refused");
  plain_forward_a: assert property (rx_frame_start_i && !ctl |=> rx_forward_o)
    else $error("plain frame not forwarded");
  pause_obey_a: assert property (rx_frame_start_i && ctl && rx_opcode_i == 16'h0001
    |=> pause_obey_o == $past(obey_pause_cfg_i)) else $error("pause reaction wrong");
  reset_state_a: assert property ($fell(rst_i) |-> mac_transmit_reset_o
    && link_speed_o == 2'h0 && !core_bus_loopback_o) else $error("bad reset state");
  line_inert_a: assert property (PORT_NUMBER != 10 && PORT_NUMBER != 11
    |-> !line_interface_reset_o) else $error("line reset on wrong port");
  line_held_a: assert property ($fell(rst_i) && PORT_NUMBER == 10
    |-> line_interface_reset_o) else $error("line reset not held");
  // Main scenarios
  cover property (req && !mapped);
  cover property (rx_frame_start_i && ctl);
  cover property (ack_o && adr_i == 8'h2c);
endmodule
`default_nettype wire

// [tb/event_src.sv]
`timescale 1ns/1ps
`default_nettype none
module event_src (
  // Clock and request
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic [9:0] req_i,
  // Event lines toward the port
  output logic      [9:0] ev_o
);
  // Registered event lines, quiet in reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ev_o <= 10'h000;
    end else begin
      ev_o <= req_i;
    end
  end
endmodule
`default_nettype wire

// [tb/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import port_mac_pkg::*;
  typedef struct packed {logic [7:0] a; logic we; logic [31:0] w; logic [31:0] x;} row_t;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0, e;
  logic rx_frame_start_i = 1'b0, obey_pause_cfg_i = 1'b1;
  logic [7:0] adr_i = 8'h00;
  logic [3:0] sel_i = 4'hf;
  logic [31:0] dat_i = 32'h0, dat_o, rd;
  logic [15:0] rx_ethertype_i = 16'h0, rx_opcode_i = 16'h0;
  logic [9:0] req = 10'h000, ev;
  logic ack_o, err_o, fwd, drop, obey, mtr, mrr, ctr, crr, prr, lrr, loop;
  link_speed_t spd;
  int error_cnt = 0, n_compared = 0;
  row_t rows [9] = '{'{8'h00, 0, 0, 32'hfc}, '{8'h04, 0, 0, 0}, '{8'h2c, 0, 0, 0},
    '{8'h00, 1, 32'hfd, 32'hfd}, '{8'h00, 1, 32'hfe, 32'hfe}, '{8'h00, 1, 32'hff, 32'hff},
    '{8'h00, 1, 32'h03, 32'h03}, '{8'h04, 1, 32'h07, 32'h07}, '{8'h04, 1, 32'h01, 32'h01}};
  // Clock
  always #50 clk_i = ~clk_i;
  event_src src (.clk_i, .rst_i, .req_i(req), .ev_o(ev));
  port_mac_status_and_mode #(.PORT_NUMBER(10)) DUT (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i,
    .adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .err_o, .rx_gap_short_i(ev[9]),
    .rx_preamble_short_i(ev[8]), .rx_extension_i(ev[7]), .rx_extension_error_i(ev[6]),
    .rx_garbage_i(ev[5]), .tx_retransmit_i(ev[4]), .tx_jamming_i(ev[3]),
    .tx_queue_overflow_i(ev[2]), .tx_oversize_i(ev[1]), .tx_abort_done_i(ev[0]),
    .rx_frame_start_i, .rx_ethertype_i, .rx_opcode_i, .obey_pause_cfg_i,
    .mac_transmit_reset_o(mtr), .mac_receive_reset_o(mrr), .coding_transmit_reset_o(ctr),
    .coding_receive_reset_o(crr), .port_reset_o(prr), .line_interface_reset_o(lrr),
    .link_speed_o(spd), .core_bus_loopback_o(loop), .rx_forward_o(fwd), .rx_drop_o(drop),
    .pause_obey_o(obey));
  //////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] g, x);
    n_compared++;
    if (g !== x) begin
      error_cnt++;
      $display("mismatch t=%0t got %h exp %h", $time, g, x);
    end
  endtask
  task automatic close_out;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // Classic single cycle, held until ack or err
  task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && err_o !== 1'b1 && n < 20);
    rd = dat_o;
    e = err_o;
    if (n >= 20) begin
      error_cnt++;
      close_out();
    end
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic fr(input logic [15:0] t, o, input logic xf, xo);
    rx_frame_start_i <= 1'b1;
    rx_ethertype_i <= t;
    rx_opcode_i <= o;
    @(posedge clk_i);
    rx_frame_start_i <= 1'b0;
    @(posedge clk_i);
    chk({fwd, drop, obey}, {xf, ~xf, xo});
  endtask
  //////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk({mtr, mrr, ctr, crr, prr, lrr, spd, loop}, 9'h1f8);
    foreach (rows[i]) begin
      if (rows[i].we) wb(rows[i].a, 1'b1, rows[i].w);
      wb(rows[i].a, 1'b0, 32'h0);
      chk(rd, rows[i].x);
      if (rows[i].a == 8'h00) chk(spd, rows[i].w[1:0]);
      if (rows[i].a == 8'h04) chk(loop, rows[i].w[0]);
    end
    chk({mtr, mrr, ctr, crr, prr, lrr}, 6'h00);
    wb(8'h10, 1'b1, 32'hff);
    chk(e, 1'b1);
    $display("register test done");
    for (int i = 0; i < 10; i++) begin
      req <= 10'h001 << i;
      @(posedge clk_i);
      req <= 10'h000;
      repeat (2) @(posedge clk_i);
      wb(8'h2c, 1'b1, 32'h0);
      wb(8'h2c, 1'b0, 32'h0);
      chk(rd, 32'h1 << i);
      wb(8'h2c, 1'b1, 32'h1 << i);
      wb(8'h2c, 1'b0, 32'h0);
      chk(rd, 32'h0);
    end
    // One-cycle event lands on the same edge as the clear
    req <= 10'h200;
    @(posedge clk_i);
    req <= 10'h000;
    wb(8'h2c, 1'b1, 32'h200);
    wb(8'h2c, 1'b0, 32'h0);
    chk(rd, 32'h200);
    $display("flag test done");
    wb(8'h04, 1'b1, 32'h0);
    fr(16'h0800, 16'h0000, 1'b1, 1'b0);
    fr(16'h8808, 16'h0001, 1'b0, 1'b1);
    fr(16'h8808, 16'h0002, 1'b0, 1'b0);
    wb(8'h04, 1'b1, 32'h6);
    fr(16'h8808, 16'h0001, 1'b1, 1'b1);
    fr(16'h8808, 16'h0005, 1'b1, 1'b0);
    obey_pause_cfg_i <= 1'b0;
    fr(16'h8808, 16'h0001, 1'b1, 1'b0);
    $display("frame test done");
    close_out();
  end
endmodule
bind port_mac_status_and_mode port_mac_chk #(.PORT_NUMBER(PORT_NUMBER)) watch (.clk_i,
  .rst_i, .cyc_i, .stb_i, .ack_o, .err_o, .adr_i, .rx_frame_start_i, .obey_pause_cfg_i,
  .rx_forward_o, .pause_obey_o, .rx_ethertype_i, .rx_opcode_i, .mac_transmit_reset_o,
  .line_interface_reset_o, .core_bus_loopback_o, .link_speed_o);
`default_nettype wire
